/* File: hw/cit_pkg.sv */
// Purpose: constants and types for the instruction timing table and address decoder
// Assumes: one instruction clock; opcode classes are presented already decoded
// Notes:   flag field order is {carry, half_carry, zero, negative}
// How it works
// - all ports, peripheral and core registers live in data space, not acc or pc.
// - data 0x00-0x3F selects scratch RAM, 0x40-0x7F the data nonvolatile array.
// - data 0x80-0x9F, 0xB8-0xBA, 0xD0-0xFF are reserved, only the reserved select set.
// - program 0x800-0xBF5 selects the code nonvolatile array.
// - vectors as byte pairs at 0xFF6, 0xFF8, 0xFFA, 0xFFC; 0xFFE-0xFFF reserved.
// - index pointer high/low at 0xBE/0xBF, stack pointer 0xCE, status 0xCF.
// - second timer reload B 0xA7/8, reload A 0xAA/B, counter 0xAC/D, control 0xAE.
// - add-with-carry 1/1 pointer, 2/3 indexed, 2/2 direct or immediate; C,H,Z,N.
// - add, and, or, xor share those counts and update only zero and negative.
// - subtract-with-carry shares those counts and updates C,H,Z,N.
// - clear 1/1 on index (Z), 1/1 accumulator and 2/1 memory (C,H,Z,N).
// - inc/dec 1/1 on index (Z), 1/1 accumulator, 2/2 memory (Z,N).
// - compare-skip 2/3 indexed, 1/1 pointer, 2/2 direct or immediate, 3/3 memory or pointer imm.
// - bit-test skips 1/1 on accumulator or pointer, 2/2 on direct memory, no flags.
// - skip on carry or no carry take 1 byte, 1 cycle, no flags.
// - set-bit and reset-bit 1/2 pointer, 2/2 direct; update zero and negative.
// - set/reset carry 1/1 C,H; invert 1/1 C; load bit 2/2 C; store bit 2/2 Z,N.
// - rotates through carry 1/1 accumulator, 2/2 memory; update C,Z,N.
// - long jump 3/4 abs, 2/3 indexed; short jump 1/1; call 3/5 and 2/5; no flags.
// - return, interrupt return and software interrupt take 1 byte, 5 cycles.
// - load 2/2 acc, 2/3 indexed, 1/1 pointer, 3/3 memory forms; store as acc forms.
// - no-operation takes 1 byte, 1 cycle, no flag change.

package cit_pkg;

   // operation classes
   typedef enum logic [4:0] {
      CIT_OP_ADC, CIT_OP_ADD, CIT_OP_AND, CIT_OP_OR, CIT_OP_XOR, CIT_OP_SUBTRACT_WITH_CARRY,
      CIT_OP_CLEAR, CIT_OP_INC, CIT_OP_DEC, CIT_OP_CMP_SKIP, CIT_OP_BIT_SKIP,
      CIT_OP_CARRY_SKIP, CIT_OP_SET_BIT, CIT_OP_SET_CARRY, CIT_OP_INV_CARRY,
      CIT_OP_LOAD_BIT, CIT_OP_STORE_BIT, CIT_OP_ROTATE, CIT_OP_LONG_JUMP,
      CIT_OP_SHORT_JUMP, CIT_OP_CALL, CIT_OP_RETURN, CIT_OP_LOAD, CIT_OP_STORE,
      CIT_OP_NOP
   } cit_op_t;

   // operand forms
   typedef enum logic [3:0] {
      CIT_FM_POINTER, CIT_FM_INDEXED, CIT_FM_DIRECT, CIT_FM_IMMEDIATE,
      CIT_FM_ACC, CIT_FM_INDEX_REG, CIT_FM_MEMORY, CIT_FM_MEM_IMM,
      CIT_FM_PTR_IMM, CIT_FM_MEM_MEM, CIT_FM_ABSOLUTE, CIT_FM_INHERENT
   } cit_form_t;

   typedef struct packed {
      logic carry;
      logic half_carry;
      logic zero;
      logic negative;
   } cit_flags_t;

   typedef struct packed {
      logic [1:0] bytes;
      logic [2:0] cycles;
      cit_flags_t touch;
   } cit_timing_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } cit_data_req_t;

   typedef struct packed {
      logic ram;
      logic data_nv;
      logic periph;
      logic core_reg;
      logic reserved;
   } cit_data_sel_t;

   typedef struct packed {
      logic       code_nv;
      logic       vector;
      logic [1:0] vector_id;
      logic       vector_hi;
      logic       reserved;
   } cit_prog_sel_t;

   localparam logic [3:0] CIT_FLAG_NONE = 4'h0;
   localparam logic [3:0] CIT_FLAG_CHZN = 4'hF;
   localparam logic [3:0] CIT_FLAG_ZN   = 4'h3;
   localparam logic [3:0] CIT_FLAG_Z    = 4'h2;
   localparam logic [3:0] CIT_FLAG_CH   = 4'hC;
   localparam logic [3:0] CIT_FLAG_C    = 4'h8;
   localparam logic [3:0] CIT_FLAG_CZN  = 4'hB;

   // data space map
   localparam logic [7:0] CIT_RAM_LO       = 8'h00;
   localparam logic [7:0] CIT_RAM_HI       = 8'h3F;
   localparam logic [7:0] CIT_DNV_LO       = 8'h40;
   localparam logic [7:0] CIT_DNV_HI       = 8'h7F;
   localparam logic [7:0] CIT_RSV0_LO      = 8'h80;
   localparam logic [7:0] CIT_RSV0_HI      = 8'h9F;
   localparam logic [7:0] CIT_RSV1_LO      = 8'hB8;
   localparam logic [7:0] CIT_RSV1_HI      = 8'hBA;
   localparam logic [7:0] CIT_RSV2_LO      = 8'hD0;
   localparam logic [7:0] CIT_RELOAD_B_LOW = 8'hA7;
   localparam logic [7:0] CIT_RELOAD_B_HI  = 8'hA8;
   localparam logic [7:0] CIT_RELOAD_A_LOW = 8'hAA;
   localparam logic [7:0] CIT_RELOAD_A_HI  = 8'hAB;
   localparam logic [7:0] CIT_COUNTER_LOW  = 8'hAC;
   localparam logic [7:0] CIT_COUNTER_HI   = 8'hAD;
   localparam logic [7:0] CIT_TIMER_CTRL   = 8'hAE;
   localparam logic [7:0] CIT_INDEX_HIGH   = 8'hBE;
   localparam logic [7:0] CIT_INDEX_LOW    = 8'hBF;
   localparam logic [7:0] CIT_STACK_PTR    = 8'hCE;
   localparam logic [7:0] CIT_CORE_STATUS  = 8'hCF;

   // program space map
   localparam logic [11:0] CIT_CODE_LO   = 12'h800;
   localparam logic [11:0] CIT_CODE_HI   = 12'hBF5;
   localparam logic [11:0] CIT_VEC_LO    = 12'hFF6;
   localparam logic [11:0] CIT_VEC_HI    = 12'hFFD;
   localparam logic [11:0] CIT_PRSV_LO   = 12'hFFE;

   localparam logic [7:0] CIT_REG_RESET = 8'h00;
   localparam logic [2:0] CIT_CYC_ONE   = 3'h1;

endpackage : cit_pkg

/* File: hw/cit_core_timing.sv */
// Purpose: instruction length/cycle/flag table, sequencer and data/program decode
// Assumes: decoded op and form arrive with issue; the core register file is local
// Notes:   the timing table is combinational; sequencing, outputs and registers are flopped
`timescale 1ns/1ps
`default_nettype none

module cit_core_timing
   import cit_pkg::*;
(
   input  wire logic          ref_clk,        // instruction clock, 125 MHz
   input  wire logic          reset_n,        // synchronous, active low
   input  wire logic          issue,          // new instruction ready to start
   input  var  cit_op_t       op,             // decoded operation class
   input  var  cit_form_t     form,           // decoded operand form
   input  var  cit_flags_t    alu_flags,      // flag results from the datapath
   input  var  cit_data_req_t data_req,       // data space access
   input  wire logic [7:0]    data_wdata,     // data write value
   input  wire logic          prog_valid,     // program space fetch strobe
   input  wire logic [11:0]   prog_addr,      // program space address
   output logic               fetch_ready,    // next instruction may be fetched
   output logic [1:0]         instr_bytes,    // length of instruction in progress
   output logic [2:0]         instr_cycles,   // cycle count of instruction in progress
   output logic               illegal_form,   // op/form pair not in the table
   output cit_flags_t         flags,          // current condition flags
   output cit_data_sel_t      data_sel,       // registered data block select
   output logic [7:0]         data_rdata,     // core register read data
   output cit_prog_sel_t      prog_sel,       // registered program block select
   output logic [7:0]         index_high,     // index pointer high byte
   output logic [7:0]         index_low,      // index pointer low byte
   output logic [7:0]         stack_ptr       // stack pointer
);

   typedef struct packed {
      logic          busy;
      logic [2:0]    remain;
      logic [1:0]    bytes;
      logic [2:0]    cycles;
      logic          illegal;
      cit_flags_t    touch;
      cit_flags_t    flags;
      logic [7:0]    idx_hi;
      logic [7:0]    idx_lo;
      logic [7:0]    sp;
      logic [7:0]    status_hi;
      cit_data_sel_t dsel;
      logic [7:0]    rdata;
      cit_prog_sel_t psel;
   } cit_state_t;

   cit_state_t  state;
   cit_state_t  next_state;
   cit_timing_t tim;
   logic        tim_ok;

   // timing lookup: bytes, cycles, flags touched per op and form
   always_comb
   begin
      tim    = '{bytes: 2'd1, cycles: 3'd1, touch: CIT_FLAG_NONE};
      tim_ok = 1'b1;
      case (op)
         CIT_OP_ADC, CIT_OP_ADD, CIT_OP_AND, CIT_OP_OR, CIT_OP_XOR, CIT_OP_SUBTRACT_WITH_CARRY:
         begin
            // carry-aware ops touch all four; logic ops only zero/negative
            tim.touch = (op == CIT_OP_ADC || op == CIT_OP_SUBTRACT_WITH_CARRY) ? CIT_FLAG_CHZN
                                                                : CIT_FLAG_ZN;
            case (form)
               CIT_FM_POINTER:   tim = '{2'd1, 3'd1, tim.touch};
               CIT_FM_INDEXED:   tim = '{2'd2, 3'd3, tim.touch};
               CIT_FM_DIRECT,
               CIT_FM_IMMEDIATE: tim = '{2'd2, 3'd2, tim.touch};
               default:          tim_ok = 1'b0;
            endcase
         end
         CIT_OP_CLEAR:
            case (form)
               CIT_FM_INDEX_REG: tim = '{2'd1, 3'd1, CIT_FLAG_Z};
               CIT_FM_ACC:       tim = '{2'd1, 3'd1, CIT_FLAG_CHZN};
               CIT_FM_MEMORY:    tim = '{2'd2, 3'd1, CIT_FLAG_CHZN};
               default:          tim_ok = 1'b0;
            endcase
         CIT_OP_INC, CIT_OP_DEC:
            case (form)
               CIT_FM_INDEX_REG: tim = '{2'd1, 3'd1, CIT_FLAG_Z};
               CIT_FM_ACC:       tim = '{2'd1, 3'd1, CIT_FLAG_ZN};
               CIT_FM_MEMORY:    tim = '{2'd2, 3'd2, CIT_FLAG_ZN};
               default:          tim_ok = 1'b0;
            endcase
         CIT_OP_CMP_SKIP:
            case (form)
               CIT_FM_INDEXED:   tim = '{2'd2, 3'd3, CIT_FLAG_NONE};
               CIT_FM_POINTER:   tim = '{2'd1, 3'd1, CIT_FLAG_NONE};
               CIT_FM_DIRECT,
               CIT_FM_IMMEDIATE: tim = '{2'd2, 3'd2, CIT_FLAG_NONE};
               CIT_FM_MEM_IMM,
               CIT_FM_PTR_IMM:   tim = '{2'd3, 3'd3, CIT_FLAG_NONE};
               default:          tim_ok = 1'b0;
            endcase
         CIT_OP_BIT_SKIP:
            case (form)
               CIT_FM_ACC,
               CIT_FM_POINTER:   tim = '{2'd1, 3'd1, CIT_FLAG_NONE};
               CIT_FM_DIRECT:    tim = '{2'd2, 3'd2, CIT_FLAG_NONE};
               default:          tim_ok = 1'b0;
            endcase
         CIT_OP_CARRY_SKIP: tim = '{2'd1, 3'd1, CIT_FLAG_NONE};
         CIT_OP_SET_BIT:
            case (form)
               CIT_FM_POINTER:   tim = '{2'd1, 3'd2, CIT_FLAG_ZN};
               CIT_FM_DIRECT:    tim = '{2'd2, 3'd2, CIT_FLAG_ZN};
               default:          tim_ok = 1'b0;
            endcase
         CIT_OP_SET_CARRY:  tim = '{2'd1, 3'd1, CIT_FLAG_CH};
         CIT_OP_INV_CARRY:  tim = '{2'd1, 3'd1, CIT_FLAG_C};
         CIT_OP_LOAD_BIT:   tim = '{2'd2, 3'd2, CIT_FLAG_C};
         CIT_OP_STORE_BIT:  tim = '{2'd2, 3'd2, CIT_FLAG_ZN};
         CIT_OP_ROTATE:
            case (form)
               CIT_FM_ACC:       tim = '{2'd1, 3'd1, CIT_FLAG_CZN};
               CIT_FM_MEMORY:    tim = '{2'd2, 3'd2, CIT_FLAG_CZN};
               default:          tim_ok = 1'b0;
            endcase
         CIT_OP_LONG_JUMP:
            case (form)
               CIT_FM_ABSOLUTE:  tim = '{2'd3, 3'd4, CIT_FLAG_NONE};
               CIT_FM_INDEXED:   tim = '{2'd2, 3'd3, CIT_FLAG_NONE};
               default:          tim_ok = 1'b0;
            endcase
         CIT_OP_SHORT_JUMP: tim = '{2'd1, 3'd1, CIT_FLAG_NONE};
         CIT_OP_CALL:
            case (form)
               CIT_FM_ABSOLUTE:  tim = '{2'd3, 3'd5, CIT_FLAG_NONE};
               CIT_FM_INDEXED:   tim = '{2'd2, 3'd5, CIT_FLAG_NONE};
               default:          tim_ok = 1'b0;
            endcase
         CIT_OP_RETURN:     tim = '{2'd1, 3'd5, CIT_FLAG_NONE};
         CIT_OP_LOAD, CIT_OP_STORE:
            case (form)
               CIT_FM_DIRECT,
               CIT_FM_IMMEDIATE: tim = '{2'd2, 3'd2, CIT_FLAG_NONE};
               CIT_FM_INDEXED:   tim = '{2'd2, 3'd3, CIT_FLAG_NONE};
               CIT_FM_POINTER:   tim = '{2'd1, 3'd1, CIT_FLAG_NONE};
               CIT_FM_MEM_IMM,
               CIT_FM_MEM_MEM,
               CIT_FM_PTR_IMM:   tim = '{2'd3, 3'd3, CIT_FLAG_NONE};
               default:          tim_ok = 1'b0;
            endcase
         CIT_OP_NOP:        tim = '{2'd1, 3'd1, CIT_FLAG_NONE};
         default:           tim_ok = 1'b0;
      endcase
      // stores have no immediate or three-byte forms
      if (op == CIT_OP_STORE && (form == CIT_FM_IMMEDIATE || form == CIT_FM_MEM_IMM ||
          form == CIT_FM_MEM_MEM || form == CIT_FM_PTR_IMM))
         tim_ok = 1'b0;
   end

   // sequencer, flag merge, core registers and decode
   always_comb
   begin
      next_state = state;
      // instruction sequencing: a new issue is only taken when idle
      if (!state.busy)
      begin
         if (issue)
         begin
            next_state.bytes   = tim.bytes;
            next_state.cycles  = tim.cycles;
            next_state.touch   = tim_ok ? tim.touch : CIT_FLAG_NONE;
            next_state.illegal = !tim_ok;
            next_state.remain  = tim.cycles - CIT_CYC_ONE;
            next_state.busy    = (tim.cycles != CIT_CYC_ONE);
            if (tim.cycles == CIT_CYC_ONE && tim_ok)
               next_state.flags = (state.flags & ~tim.touch) | (alu_flags & tim.touch);
         end
      end
      else
      begin
         next_state.remain = state.remain - CIT_CYC_ONE;
         if (state.remain == CIT_CYC_ONE)
         begin
            next_state.busy  = 1'b0;
            // flags land in the last cycle; untouched flags hold
            next_state.flags = (state.flags & ~state.touch) | (alu_flags & state.touch);
         end
      end

      // data space decode, one cycle after the request
      next_state.dsel  = '0;
      next_state.rdata = CIT_REG_RESET;
      if (data_req.valid)
      begin
         if (data_req.addr <= CIT_RAM_HI)
            next_state.dsel.ram = 1'b1;
         else if (data_req.addr >= CIT_DNV_LO && data_req.addr <= CIT_DNV_HI)
            next_state.dsel.data_nv = 1'b1;
         else if ((data_req.addr >= CIT_RSV0_LO && data_req.addr <= CIT_RSV0_HI) ||
                  (data_req.addr >= CIT_RSV1_LO && data_req.addr <= CIT_RSV1_HI) ||
                  data_req.addr >= CIT_RSV2_LO)
            next_state.dsel.reserved = 1'b1;
         else if (data_req.addr == CIT_INDEX_HIGH || data_req.addr == CIT_INDEX_LOW ||
                  data_req.addr == CIT_STACK_PTR || data_req.addr == CIT_CORE_STATUS)
            next_state.dsel.core_reg = 1'b1;
         else
            next_state.dsel.periph = 1'b1;
         // core registers; acc and pc have no address here
         case (data_req.addr)
            CIT_INDEX_HIGH:
               if (data_req.write) next_state.idx_hi = data_wdata;
               else next_state.rdata = state.idx_hi;
            CIT_INDEX_LOW:
               if (data_req.write) next_state.idx_lo = data_wdata;
               else next_state.rdata = state.idx_lo;
            CIT_STACK_PTR:
               if (data_req.write) next_state.sp = data_wdata;
               else next_state.rdata = state.sp;
            CIT_CORE_STATUS:
               if (data_req.write)
               begin
                  next_state.status_hi = {data_wdata[7:4], 4'h0};
                  next_state.flags     = data_wdata[3:0];
               end
               else
                  next_state.rdata = {state.status_hi[7:4], state.flags};
            default: next_state.rdata = CIT_REG_RESET;
         endcase
      end

      // program space decode
      next_state.psel = '0;
      if (prog_valid)
      begin
         if (prog_addr >= CIT_CODE_LO && prog_addr <= CIT_CODE_HI)
            next_state.psel.code_nv = 1'b1;
         else if (prog_addr >= CIT_VEC_LO && prog_addr <= CIT_VEC_HI)
         begin
            // pairs: 0xFF6 first timer ... 0xFFC software, low bit picks the byte
            next_state.psel.vector    = 1'b1;
            next_state.psel.vector_id = 2'((prog_addr - CIT_VEC_LO) >> 1);
            next_state.psel.vector_hi = prog_addr[0];
         end
         else if (prog_addr >= CIT_PRSV_LO)
            next_state.psel.reserved = 1'b1;
         else
            next_state.psel.reserved = 1'b1;
      end

      if (!reset_n)
      begin
         next_state = '0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      state <= next_state;
   end

   assign fetch_ready  = !state.busy;
   assign instr_bytes  = state.bytes;
   assign instr_cycles = state.cycles;
   assign illegal_form = state.illegal;
   assign flags        = state.flags;
   assign data_sel     = state.dsel;
   assign data_rdata   = state.rdata;
   assign prog_sel     = state.psel;
   assign index_high   = state.idx_hi;
   assign index_low    = state.idx_lo;
   assign stack_ptr    = state.sp;

endmodule // cit_core_timing

`default_nettype wire

/* File: tb/cit_core_timing_assertions.sv */
// Purpose: port checks of the decode windows and the instruction sequencer
// Assumes: one clock, synchronous active-low reset
// Notes:   selects are one-hot codes {ram,data_nv,periph,core_reg,reserved}
`timescale 1ns/1ps
`default_nettype none
module cit_core_timing_assertions
   import cit_pkg::*;
(
   input wire logic          ref_clk,      // instruction clock
   input wire logic          reset_n,      // synchronous reset
   input wire logic          issue,        // instruction start
   input var  cit_data_req_t data_req,     // data access
   input wire logic          prog_valid,   // program fetch strobe
   input wire logic [11:0]   prog_addr,    // program address
   input wire logic          fetch_ready,  // sequencer idle
   input wire logic [2:0]    instr_cycles, // accepted cycle count
   input var  cit_data_sel_t data_sel,     // data block select
   input wire logic [7:0]    data_rdata,   // core read data
   input var  cit_prog_sel_t prog_sel      // program block select
);
   // all checks share the clock; reset masks them so stale history is ignored
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_ram_window:
      assert property (data_req.valid && data_req.addr <= 8'h3F |=> data_sel == 5'h10)
      else $error("ram window not selected alone");
   a_nv_window:
      assert property (data_req.valid && data_req.addr inside {[8'h40:8'h7F]}
         |=> data_sel == 5'h08) else $error("data array window not selected alone");
   a_reserved_read:
      assert property (data_req.valid && data_req.addr inside {[8'h80:8'h9F],
         [8'hB8:8'hBA], [8'hD0:8'hFF]} |=> data_sel == 5'h01 && data_rdata == 8'h00)
      else $error("reserved data address answered");
   a_core_regs:
      assert property (data_req.valid && data_req.addr inside {8'hBE, 8'hBF, 8'hCE, 8'hCF}
         |=> data_sel == 5'h02) else $error("core register not selected");
   a_timer_regs:
      assert property (data_req.valid && data_req.addr inside {[8'hA7:8'hA8], [8'hAA:8'hAE]}
         |=> data_sel == 5'h04) else $error("timer register not in peripheral space");
   a_code_window:
      assert property (prog_valid && prog_addr inside {[12'h800:12'hBF5]}
         |=> prog_sel.code_nv && !prog_sel.vector && !prog_sel.reserved)
      else $error("code window not selected");
   a_vector_pair:
      assert property (prog_valid && prog_addr inside {[12'hFF6:12'hFFD]} |=> prog_sel.vector
         && {1'b0, prog_sel.vector_id} == $past(prog_addr[3:1]) - 3'h3
         && prog_sel.vector_hi == $past(prog_addr[0])) else $error("vector pair misdecoded");
   a_one_cycle:
      assert property (fetch_ready && issue ##1 instr_cycles == 3'h1 |-> fetch_ready)
      else $error("single cycle op stalled fetch");
   a_three_cycle:
      assert property (fetch_ready && issue ##1 instr_cycles == 3'h3
         |-> !fetch_ready [*2] ##1 fetch_ready) else $error("three cycle op wrong length");
   a_five_cycle:
      assert property (fetch_ready && issue ##1 instr_cycles == 3'h5
         |-> !fetch_ready [*4] ##1 fetch_ready) else $error("five cycle op wrong length");
endmodule // cit_core_timing_assertions

bind cit_core_timing cit_core_timing_assertions chk_u (.ref_clk(ref_clk), .reset_n(reset_n),
   .issue(issue), .data_req(data_req), .prog_valid(prog_valid), .prog_addr(prog_addr),
   .fetch_ready(fetch_ready), .instr_cycles(instr_cycles), .data_sel(data_sel),
   .data_rdata(data_rdata), .prog_sel(prog_sel));
`default_nettype wire

/* File: tb/cit_mem_model.sv */
// Purpose: behavioural scratch ram and data array behind the data decoder
// Assumes: selects arrive one cycle after the request
// Notes:   unselected cycles invert the read bus so a stale value cannot match
`timescale 1ns/1ps
`default_nettype none
module cit_mem_model
   import cit_pkg::*;
(
   input wire logic          ref_clk,    // instruction clock
   input var  cit_data_req_t data_req,   // request as the core issues it
   input wire logic [7:0]    data_wdata, // write value
   input var  cit_data_sel_t data_sel,   // decoder select
   output logic [7:0]        mem_rdata   // ram or data array read value
);
   logic [7:0]    store [128];
   cit_data_req_t held_req;
   logic [7:0]    held_wdata;

   initial mem_rdata = 8'h00;
   // answer only when the decoder picks one of the two arrays
   always @(posedge ref_clk)
   begin
      held_req <= data_req;
      held_wdata <= data_wdata;
      if ((data_sel.ram || data_sel.data_nv) && held_req.write)
         store[held_req.addr[6:0]] <= held_wdata;
      else if (data_sel.ram || data_sel.data_nv)
         mem_rdata <= store[held_req.addr[6:0]];
      else
         mem_rdata <= ~mem_rdata;
   end
endmodule // cit_mem_model
`default_nettype wire

/* File: tb/cit_core_timing_bench.sv */
// Purpose: directed bench for timing table, flag masks and address decode
// Assumes: datapath flags held steady while an instruction runs
// Notes:   datapath flags are the inverse of the current flags, so any touch shows
`timescale 1ns/1ps
`default_nettype none
module cit_core_timing_bench
   import cit_pkg::*;
;
   typedef struct packed {
      cit_op_t    op;
      cit_form_t  form;
      logic [1:0] bytes;
      logic [2:0] cycles;
      logic [3:0] touch;
   } cit_tb_row_t;
   logic          ref_clk, reset_n, issue, prog_valid, fetch_ready, illegal_form;
   logic [1:0]    instr_bytes;
   logic [2:0]    instr_cycles;
   logic [7:0]    data_wdata, data_rdata, mem_rdata, index_high, index_low, stack_ptr;
   logic [11:0]   prog_addr;
   cit_op_t       op;
   cit_form_t     form;
   cit_flags_t    alu_flags, flags, cur_flags;
   cit_data_req_t data_req;
   cit_data_sel_t data_sel;
   cit_prog_sel_t prog_sel;
   int            error_cnt, samples_checked;
   logic [7:0]    wa [9] = '{8'hBE, 8'hBF, 8'hCE, 8'hCF, 8'hBA, 8'hD0, 8'h80, 8'h3F, 8'h40};
   logic [7:0]    wd [9] = '{8'h5A, 8'hC3, 8'h7E, 8'h96, 8'hFF, 8'hFF, 8'hFF, 8'hA5, 8'h3C};
   logic [11:0]   pa [15] = '{12'h7FF, 12'h800, 12'hBF5, 12'hBF6, 12'hFF5, 12'hFF6, 12'hFF7,
      12'hFF8, 12'hFF9, 12'hFFA, 12'hFFB, 12'hFFC, 12'hFFD, 12'hFFE, 12'hFFF};
   localparam cit_tb_row_t TAB [27] = '{
      '{CIT_OP_ADC, CIT_FM_POINTER, 2'h1, 3'h1, 4'hF}, '{CIT_OP_ADC, CIT_FM_INDEXED, 2'h2, 3'h3, 4'hF},
      '{CIT_OP_ADD, CIT_FM_DIRECT, 2'h2, 3'h2, 4'h3}, '{CIT_OP_AND, CIT_FM_IMMEDIATE, 2'h2, 3'h2, 4'h3},
      '{CIT_OP_OR, CIT_FM_INDEXED, 2'h2, 3'h3, 4'h3}, '{CIT_OP_XOR, CIT_FM_POINTER, 2'h1, 3'h1, 4'h3},
      '{CIT_OP_SUBTRACT_WITH_CARRY, CIT_FM_DIRECT, 2'h2, 3'h2, 4'hF}, '{CIT_OP_SUBTRACT_WITH_CARRY, CIT_FM_INDEXED, 2'h2, 3'h3, 4'hF},
      '{CIT_OP_CLEAR, CIT_FM_INDEX_REG, 2'h1, 3'h1, 4'h2}, '{CIT_OP_CLEAR, CIT_FM_MEMORY, 2'h2, 3'h1, 4'hF},
      '{CIT_OP_CLEAR, CIT_FM_ACC, 2'h1, 3'h1, 4'hF}, '{CIT_OP_INC, CIT_FM_INDEX_REG, 2'h1, 3'h1, 4'h2},
      '{CIT_OP_DEC, CIT_FM_MEMORY, 2'h2, 3'h2, 4'h3}, '{CIT_OP_CMP_SKIP, CIT_FM_MEM_IMM, 2'h3, 3'h3, 4'h0},
      '{CIT_OP_CMP_SKIP, CIT_FM_INDEXED, 2'h2, 3'h3, 4'h0}, '{CIT_OP_BIT_SKIP, CIT_FM_ACC, 2'h1, 3'h1, 4'h0},
      '{CIT_OP_CARRY_SKIP, CIT_FM_INHERENT, 2'h1, 3'h1, 4'h0}, '{CIT_OP_SET_BIT, CIT_FM_POINTER, 2'h1, 3'h2, 4'h3},
      '{CIT_OP_SET_CARRY, CIT_FM_INHERENT, 2'h1, 3'h1, 4'hC}, '{CIT_OP_INV_CARRY, CIT_FM_INHERENT, 2'h1, 3'h1, 4'h8},
      '{CIT_OP_ROTATE, CIT_FM_ACC, 2'h1, 3'h1, 4'hB}, '{CIT_OP_ROTATE, CIT_FM_MEMORY, 2'h2, 3'h2, 4'hB},
      '{CIT_OP_LONG_JUMP, CIT_FM_ABSOLUTE, 2'h3, 3'h4, 4'h0}, '{CIT_OP_CALL, CIT_FM_INDEXED, 2'h2, 3'h5, 4'h0},
      '{CIT_OP_RETURN, CIT_FM_INHERENT, 2'h1, 3'h5, 4'h0}, '{CIT_OP_LOAD, CIT_FM_MEM_MEM, 2'h3, 3'h3, 4'h0},
      '{CIT_OP_NOP, CIT_FM_INHERENT, 2'h1, 3'h1, 4'h0}};

   cit_core_timing dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .issue(issue), .op(op),
      .form(form), .alu_flags(alu_flags), .data_req(data_req), .data_wdata(data_wdata),
      .prog_valid(prog_valid), .prog_addr(prog_addr), .fetch_ready(fetch_ready),
      .instr_bytes(instr_bytes), .instr_cycles(instr_cycles), .illegal_form(illegal_form),
      .flags(flags), .data_sel(data_sel), .data_rdata(data_rdata), .prog_sel(prog_sel),
      .index_high(index_high), .index_low(index_low), .stack_ptr(stack_ptr));
   cit_mem_model mem_u (.ref_clk(ref_clk), .data_req(data_req), .data_wdata(data_wdata),
      .data_sel(data_sel), .mem_rdata(mem_rdata));

   // free-running 8 ns clock
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // expected data select, peripheral space is whatever no other window claims
   function automatic cit_data_sel_t exp_dsel(input logic [7:0] a);
      cit_data_sel_t s;
      s = '0;
      if (a <= 8'h3F) s.ram = 1'b1;
      else if (a <= 8'h7F) s.data_nv = 1'b1;
      else if (a <= 8'h9F || (a >= 8'hB8 && a <= 8'hBA) || a >= 8'hD0) s.reserved = 1'b1;
      else if (a == 8'hBE || a == 8'hBF || a == 8'hCE || a == 8'hCF) s.core_reg = 1'b1;
      else s.periph = 1'b1;
      return s;
   endfunction

   function automatic cit_prog_sel_t exp_psel(input logic [11:0] a);
      cit_prog_sel_t s;
      s = '0;
      if (a >= 12'h800 && a <= 12'hBF5) s.code_nv = 1'b1;
      else if (a >= 12'hFF6 && a <= 12'hFFD) s = '{1'b0, 1'b1, 2'((a - 12'hFF6) >> 1), a[0], 1'b0};
      else s.reserved = 1'b1;
      return s;
   endfunction

   // one data access; the select is looked at in the cycle after the request
   task automatic dacc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] rd);
      @(posedge ref_clk);
      data_req <= '{1'b1, w, a};
      data_wdata <= d;
      @(posedge ref_clk);
      data_req <= '0;
      #1;
      check(data_sel, exp_dsel(a));
      if (!w) check(data_rdata, rd);
   endtask

   task automatic run_op(input cit_tb_row_t r);
      int         n;
      cit_flags_t exp_f;
      exp_f = cur_flags ^ r.touch;
      @(posedge ref_clk);
      issue <= 1'b1;
      op <= r.op;
      form <= r.form;
      alu_flags <= ~cur_flags;
      @(posedge ref_clk);
      issue <= 1'b0;
      #1;
      n = 1;
      while (fetch_ready !== 1'b1 && n < 8) begin @(posedge ref_clk); #1; n++; end
      if (n == 8) begin error_cnt++; close_out(); end
      check(12'(n), r.cycles);
      check(instr_cycles, r.cycles);
      check(instr_bytes, r.bytes);
      check(flags, exp_f);
      cur_flags = exp_f;
   endtask

   // reset, sweep the data map, registers, program map, then the timing table
   initial
   begin
      {reset_n, issue, prog_valid, data_wdata, prog_addr, alu_flags, data_req} = '0;
      {error_cnt, samples_checked, cur_flags} = '0;
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      check(fetch_ready, 1'b1);
      check(flags, 4'h0);
      for (int a = 0; a < 256; a++) dacc(1'b0, a[7:0], 8'h00, 8'h00);
      foreach (wa[i]) dacc(1'b1, wa[i], wd[i], 8'h00);
      foreach (wa[i])
      begin
         dacc(1'b0, wa[i], 8'h00, (i < 4) ? wd[i] : 8'h00);
         @(posedge ref_clk);
         #1;
         if (i >= 7) check(mem_rdata, wd[i]);
      end
      check(index_high, 8'h5A);
      check(index_low, 8'hC3);
      check(stack_ptr, 8'h7E);
      check(flags, 4'h6);
      cur_flags = 4'h6;
      foreach (pa[i])
      begin
         @(posedge ref_clk);
         prog_valid <= 1'b1;
         prog_addr <= pa[i];
         @(posedge ref_clk);
         prog_valid <= 1'b0;
         #1;
         check(prog_sel, exp_psel(pa[i]));
      end
      foreach (TAB[i]) run_op(TAB[i]);
      run_op('{CIT_OP_CLEAR, CIT_FM_INDEXED, 2'h1, 3'h1, 4'h0});
      check(illegal_form, 1'b1);
      close_out();
   end
endmodule // cit_core_timing_bench
`default_nettype wire
